// [inc/ppc_pkg.sv]
// Shared constants and types for the per-port class and power controller.
// Assumes a single 40 MHz clock domain.
package ppc_pkg;

    // Clock period in picoseconds; scaling per microsecond keeps products inside 32 bits
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CYC_PER_US = 1000000 / CLK_PERIOD_PS;

    // Classification interval, mark pause and inrush start window
    localparam int CLASS_TIME_US = 12000;
    localparam int MARK_TIME_US = 100;
    localparam int START_TIME_US = 60000;
    localparam int CLASS_CYC = CLASS_TIME_US * CYC_PER_US;
    localparam int MARK_CYC = MARK_TIME_US * CYC_PER_US;
    localparam int START_CYC = START_TIME_US * CYC_PER_US;

    // Overload and limit timer trip count; down-count divider is 16
    localparam int FAULT_TIME_US = 60000;
    localparam int FAULT_CYC = FAULT_TIME_US * CYC_PER_US;
    localparam logic [3:0] DOWN_DIV_MAX = 4'hf;

    // Current limit codes
    localparam logic [7:0] CURRENT_LIMIT_THRESHOLD_DEF_LARGE_R = 8'h00;
    localparam logic [7:0] CURRENT_LIMIT_THRESHOLD_T2_LARGE_R = 8'h40;
    localparam logic [7:0] CURRENT_LIMIT_THRESHOLD_DEF_SMALL_R = 8'h80;
    localparam logic [7:0] CURRENT_LIMIT_THRESHOLD_T2_SMALL_R = 8'hc0;
    localparam logic [1:0] FOLDBACK_RST = 2'h0;
    localparam logic [6:0] OVERLOAD_CUT_THRESHOLD_RST = 7'h00;

    // Class codes
    localparam logic [2:0] CLASS_4 = 3'h4;
    localparam logic [2:0] CLASS_RST = 3'h0;

    // Voltage drive selections toward the analog front end
    typedef enum logic [1:0] {
        PPC_DRV_OFF = 2'b00,
        PPC_DRV_CLASS = 2'b01,
        PPC_DRV_MARK = 2'b10
    } ppc_drive_type;

    typedef enum logic [3:0] {
        PPC_IDLE = 4'b0000,
        PPC_DETECT = 4'b0001,
        PPC_CLASS1 = 4'b0010,
        PPC_MARK = 4'b0011,
        PPC_CLASS2 = 4'b0100,
        PPC_WAIT_ON = 4'b0101,
        PPC_INRUSH = 4'b0110,
        PPC_POWERED = 4'b0111,
        PPC_OFF = 4'b1000
    } ppc_state_type;

endpackage : ppc_pkg

// [rtl/ppc_fault_timer.sv]
// Asymmetric fault accumulator: counts up while over, down at 1/16 rate.
// Assumes 'over' is already synchronised to clk.
`timescale 1ns/100ps
module ppc_fault_timer
    import ppc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic over,
    input wire logic [23:0] trip,
    output logic expired
);
    logic [23:0] acc_r;
    logic [3:0] div_r;

    // Down step only every sixteenth cycle, so short bursts accumulate
    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            acc_r <= 24'h000000;
            div_r <= 4'h0;
        end else if (over) begin
            if (acc_r != trip) acc_r <= acc_r + 24'h000001;
        end else begin
            div_r <= div_r + 4'h1;
            if (div_r == DOWN_DIV_MAX && acc_r != 24'h000000) acc_r <= acc_r - 24'h000001;
        end
    end

    assign expired = (acc_r == trip);
endmodule : ppc_fault_timer

// [rtl/ppc_interval.sv]
// Down-counting interval timer used for class, mark and start windows.
// Assumes load and count come from the same clock domain.
`timescale 1ns/100ps
module ppc_interval (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [23:0] count,
    output logic done
);
    logic [23:0] cnt_r;

    // Load restarts; done pulses when count reaches one
    always_ff @(posedge clk) begin
        if (sys_rst || load) begin
            cnt_r <= sys_rst ? 24'h000000 : count;
        end else if (cnt_r != 24'h000000) begin
            cnt_r <= cnt_r - 24'h000001;
        end
    end

    assign done = (cnt_r == 24'h000001);
endmodule : ppc_interval

// [rtl/ppc_port_ctrl.sv]
// Per-port sequencer: classification with mark event, inrush, overload
// and limit timers, and current-limit selection.
// Assumes analog status inputs arrive asynchronously from the front end.
//
// Notes on behaviour
// R1: Class 4 with option: mark, pause, reclassify
// R2: Set flag when second classification ran
// R3: Second event only when enable bit set
// R4: Class 0-3 first: skip, treat Type 1
// R5: Auto mode: 4 then 0-3 withholds, redetects
// R6: Class output holds latest pulse result
// R7: Thresholds accepted while powered
// R8: Power-on: inrush limit, start timer runs
// R9: Start timer expiry: off, start fault
// R10: Overload only: no limit, timer up
// R11: Limit active: limit timer runs; code runs it only while powered and holds it clear during inrush
// R12: Timers count down at 1/16 rate
// R13: Timer expiry removes port power
// R14: Inrush uses default limit, then programmed
// R15: Port off restores default limit
// R16: Host programs default or Type 2 limit
// R17: Limit code depends on sense resistor
// R18: Two scalings, larger resistor default
// R19: Limit and foldback per port
// R20: Auto mode powers on without command
// R21: Class voltage fixed interval, measure current
// R22: State machine sequences the port
`timescale 1ns/100ps
module ppc_port_ctrl
    import ppc_pkg::*;
#(
    parameter int CLASS_CYCLES = CLASS_CYC,
    parameter int MARK_CYCLES = MARK_CYC,
    parameter int START_CYCLES = START_CYC,
    parameter int FAULT_CYCLES = FAULT_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic auto_mode,
    input wire logic detect_en,
    input wire logic class_en,
    input wire logic second_event_en,
    input wire logic small_sense_r,
    input wire logic power_on_cmd,
    input wire logic power_off_cmd,
    input wire logic [7:0] host_current_limit_threshold,
    input wire logic [6:0] host_overload_cut_threshold,
    input wire logic [1:0] host_foldback,
    input wire logic detect_done,
    input wire logic detect_good,
    input wire logic [2:0] class_meas,
    input wire logic inrush_done,
    input wire logic over_overload_cut_threshold,
    input wire logic over_current_limit_threshold,
    output logic [1:0] drive_sel,
    output logic detect_req,
    output logic gate_en,
    output logic limit_active,
    output logic [7:0] current_limit_threshold,
    output logic [6:0] overload_cut_threshold,
    output logic [1:0] foldback_sel,
    output logic [2:0] class_result,
    output logic second_class_ran,
    output logic type2_pd,
    output logic start_fault,
    output logic overload_fault,
    output logic limit_fault,
    output logic power_good
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers: two flops before any logic

    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [2:0] cls1_r;
    logic [2:0] cls2_r;

    always_ff @(posedge clk) begin
        sync1_r <= {detect_done, detect_good, inrush_done, over_overload_cut_threshold, over_current_limit_threshold};
        sync2_r <= sync1_r;
        cls1_r <= class_meas;
        cls2_r <= cls1_r;
    end

    wire det_done_s = sync2_r[4];
    wire det_good_s = sync2_r[3];
    wire inrush_done_s = sync2_r[2];
    wire over_overload_cut_threshold_s = sync2_r[1];
    wire over_current_limit_threshold_s = sync2_r[0];

    ////////////////////////////////////////////////////////////////////
    // State and timers

    ppc_state_type state_r;
    ppc_state_type state_nxt;
    logic iv_load;
    logic [23:0] iv_count;
    logic iv_done;
    logic first_was4_r;
    logic cut_exp;
    logic lim_exp;

    ppc_interval u_interval (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(iv_load),
        .count(iv_count),
        .done(iv_done)
    );

    // Limit flag reflects active limiting during inrush and while powered
    wire limiting = over_current_limit_threshold_s && (state_r == PPC_INRUSH || state_r == PPC_POWERED);
    wire timers_clr = (state_r != PPC_POWERED);

    ppc_fault_timer u_cut_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(timers_clr),
        .over(over_overload_cut_threshold_s), // R10 R12
        .trip(FAULT_CYCLES[23:0]),
        .expired(cut_exp)
    );

    ppc_fault_timer u_lim_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(timers_clr),
        .over(limiting), // R11 R12
        .trip(FAULT_CYCLES[23:0]),
        .expired(lim_exp)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencing decisions

    wire cls_is4 = (cls2_r == CLASS_4);
    wire do_second = second_event_en && cls_is4; // R1 R3 R4
    wire invalid_t2 = first_was4_r && !cls_is4; // R5
    wire can_power = auto_mode || power_on_cmd; // R20
    wire trip_now = cut_exp || lim_exp; // R13

    // Next-state logic; faults and off commands during inrush or powered go to OFF
    always_comb begin
        state_nxt = state_r;
        iv_load = 1'b0;
        iv_count = 24'h000000;
        unique case (state_r)
            PPC_IDLE: begin
                if (detect_en) state_nxt = PPC_DETECT;
            end
            PPC_DETECT: begin
                if (det_done_s && det_good_s) begin
                    state_nxt = class_en ? PPC_CLASS1 : PPC_WAIT_ON;
                    iv_load = class_en;
                    iv_count = CLASS_CYCLES[23:0]; // R21
                end else if (det_done_s) begin
                    state_nxt = PPC_IDLE;
                end
            end
            PPC_CLASS1: begin
                if (iv_done && do_second) begin
                    state_nxt = PPC_MARK; // R1
                    iv_load = 1'b1;
                    iv_count = MARK_CYCLES[23:0];
                end else if (iv_done) begin
                    state_nxt = PPC_WAIT_ON; // R4
                end
            end
            PPC_MARK: begin
                if (iv_done) begin
                    state_nxt = PPC_CLASS2;
                    iv_load = 1'b1;
                    iv_count = CLASS_CYCLES[23:0]; // R21
                end
            end
            PPC_CLASS2: begin
                if (iv_done && auto_mode && invalid_t2) state_nxt = PPC_IDLE; // R5
                else if (iv_done) state_nxt = PPC_WAIT_ON;
            end
            PPC_WAIT_ON: begin
                if (can_power) begin
                    state_nxt = PPC_INRUSH; // R8
                    iv_load = 1'b1;
                    iv_count = START_CYCLES[23:0];
                end else if (!detect_en) begin
                    state_nxt = PPC_IDLE;
                end
            end
            PPC_INRUSH: begin
                if (inrush_done_s) state_nxt = PPC_POWERED;
                else if (iv_done || power_off_cmd) state_nxt = PPC_OFF; // R9
            end
            PPC_POWERED: begin
                if (trip_now || power_off_cmd) state_nxt = PPC_OFF; // R13
            end
            PPC_OFF: begin
                state_nxt = PPC_IDLE;
            end
            default: state_nxt = PPC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) state_r <= PPC_IDLE;
        else state_r <= state_nxt; // R22
    end

    ////////////////////////////////////////////////////////////////////
    // Class results and flags; latest pulse always wins

    wire class_end = iv_done && (state_r == PPC_CLASS1 || state_r == PPC_CLASS2);
    wire start_exp = (state_r == PPC_INRUSH) && iv_done && !inrush_done_s;
    wire in_power = (state_nxt == PPC_INRUSH || state_nxt == PPC_POWERED);
    wire to_off = (state_nxt == PPC_OFF);
    // Default code tracks sense resistor; larger one is reset choice
    wire [7:0] current_limit_threshold_default = small_sense_r ? CURRENT_LIMIT_THRESHOLD_DEF_SMALL_R : CURRENT_LIMIT_THRESHOLD_DEF_LARGE_R; // R17 R18

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            class_result <= CLASS_RST;
            first_was4_r <= 1'b0;
            second_class_ran <= 1'b0;
            type2_pd <= 1'b0;
        end else begin
            if (class_end) class_result <= cls2_r; // R6
            if (class_end && state_r == PPC_CLASS1) first_was4_r <= cls_is4;
            if (state_r == PPC_CLASS1 && state_nxt == PPC_MARK) second_class_ran <= 1'b1; // R2
            else if (state_r == PPC_DETECT && state_nxt == PPC_CLASS1) second_class_ran <= 1'b0;
            if (class_end && state_r == PPC_CLASS2) type2_pd <= cls_is4 && first_was4_r;
            else if (class_end) type2_pd <= 1'b0; // R4
        end
    end

    // Fault flags are sticky until the next power-on attempt
    always_ff @(posedge clk) begin
        if (sys_rst || (state_r == PPC_WAIT_ON && can_power)) begin
            start_fault <= 1'b0;
            overload_fault <= 1'b0;
            limit_fault <= 1'b0;
        end else begin
            if (start_exp) start_fault <= 1'b1; // R9
            if (state_r == PPC_POWERED && cut_exp) overload_fault <= 1'b1; // R13
            if (state_r == PPC_POWERED && lim_exp) limit_fault <= 1'b1; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output registers toward the power stage

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drive_sel <= PPC_DRV_OFF;
            detect_req <= 1'b0;
            gate_en <= 1'b0;
            power_good <= 1'b0;
            limit_active <= 1'b0;
            current_limit_threshold <= CURRENT_LIMIT_THRESHOLD_DEF_LARGE_R;
            overload_cut_threshold <= OVERLOAD_CUT_THRESHOLD_RST;
            foldback_sel <= FOLDBACK_RST;
        end else begin
            drive_sel <= (state_nxt == PPC_CLASS1 || state_nxt == PPC_CLASS2) ? PPC_DRV_CLASS :
                         (state_nxt == PPC_MARK) ? PPC_DRV_MARK : PPC_DRV_OFF; // R1 R21
            detect_req <= (state_nxt == PPC_DETECT);
            gate_en <= in_power; // R8
            power_good <= (state_nxt == PPC_POWERED);
            limit_active <= limiting; // R10 R11
            // Inrush and off use default; powered follows host, live
            if (to_off || state_nxt == PPC_INRUSH || !in_power) begin
                current_limit_threshold <= current_limit_threshold_default; // R14 R15
            end else begin
                current_limit_threshold <= host_current_limit_threshold; // R7 R14
            end
            overload_cut_threshold <= host_overload_cut_threshold; // R7
            foldback_sel <= host_foldback; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    AST_MARK_AFTER_CLASS4: assert property (@(posedge clk) disable iff (sys_rst) // R1
        (state_r == PPC_CLASS1 && iv_done && second_event_en && cls_is4)
        |=> state_r == PPC_MARK ##1 drive_sel == PPC_DRV_MARK)
        else $error("mark not entered after class 4");
    AST_FLAG_SET: assert property (@(posedge clk) disable iff (sys_rst) // R2
        (state_r == PPC_MARK) |-> second_class_ran)
        else $error("second class flag missing");
    AST_NO_SECOND_OFF: assert property (@(posedge clk) disable iff (sys_rst) // R3
        (state_r == PPC_CLASS1 && !second_event_en) |=> state_r != PPC_MARK)
        else $error("second event ran while disabled");
    AST_SKIP_LOW: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (state_r == PPC_CLASS1 && iv_done && !cls_is4) |=> state_r == PPC_WAIT_ON)
        else $error("second class ran after class 0-3");
    AST_INVALID_T2: assert property (@(posedge clk) disable iff (sys_rst) // R5
        (state_r == PPC_CLASS2 && iv_done && auto_mode && first_was4_r && !cls_is4)
        |=> state_r == PPC_IDLE ##1 !gate_en)
        else $error("invalid type 2 powered");
    AST_CLASS_LATEST: assert property (@(posedge clk) disable iff (sys_rst) // R6
        class_end |=> class_result == $past(cls2_r))
        else $error("class result not latest");
    AST_INRUSH_ON: assert property (@(posedge clk) disable iff (sys_rst) // R8
        (state_r == PPC_WAIT_ON && can_power)
        |=> state_r == PPC_INRUSH && gate_en && current_limit_threshold == $past(current_limit_threshold_default))
        else $error("power request did not start inrush");
    AST_START_FAULT: assert property (@(posedge clk) disable iff (sys_rst) // R9
        start_exp |=> state_r == PPC_OFF && start_fault ##1 !gate_en)
        else $error("start timeout not handled");
    AST_CUT_NO_LIMIT: assert property (@(posedge clk) disable iff (sys_rst) // R10
        (over_overload_cut_threshold_s && !over_current_limit_threshold_s) |=> !limit_active)
        else $error("limiting on overload alone");
    AST_INRUSH_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst) // R14
        (state_r == PPC_INRUSH && $past(state_r) == PPC_INRUSH)
        |-> current_limit_threshold == current_limit_threshold_default || $changed(small_sense_r))
        else $error("inrush limit not default");
    AST_OFF_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst) // R15
        (state_r == PPC_OFF) |=> current_limit_threshold == $past(current_limit_threshold_default))
        else $error("limit not restored at off");
    AST_TRIP_OFF: assert property (@(posedge clk) disable iff (sys_rst) // R13
        (state_r == PPC_POWERED && trip_now) |=> state_r == PPC_OFF ##1 !power_good)
        else $error("expired timer did not remove power");

endmodule : ppc_port_ctrl

// [verif/ppc_pd_model.sv]
// Powered device model on the cable side of one port.
// Assumes the controller's outputs are registered on clk.
`timescale 1ns/100ps
module ppc_pd_model
    import ppc_pkg::*;
(
    input wire logic clk,
    input wire logic [1:0] drive_sel,
    input wire logic detect_req,
    input wire logic gate_en,
    input wire logic sig_good,
    input wire logic [2:0] class_a,
    input wire logic [2:0] class_b,
    input wire logic [7:0] inrush_len,
    input wire logic load_cut,
    input wire logic load_lim,
    output logic detect_done = 1'b0,
    output logic detect_good = 1'b0,
    output logic [2:0] class_meas = 3'h0,
    output logic inrush_done = 1'b0,
    output logic over_overload_cut_threshold,
    output logic over_current_limit_threshold
);
    logic [1:0] det_r = 2'h0;
    logic pulse_r = 1'b0;
    logic [7:0] chg_r = 8'h00;
    //////////////////////////////////////////////////
    // Signature after a short settle; idle lines toggle so stale data never looks valid
    always_ff @(posedge clk) begin
        det_r <= detect_req ? det_r + {1'b0, det_r != 2'h3} : 2'h0;
        detect_done <= detect_req && det_r == 2'h3;
        detect_good <= detect_req ? sig_good : ~detect_good;
        pulse_r <= detect_req ? 1'b0 : (pulse_r || drive_sel == PPC_DRV_MARK);
        class_meas <= (drive_sel == PPC_DRV_CLASS) ? (pulse_r ? class_b : class_a)
                      : ~class_meas;
    end
    // Output capacitance charges for inrush_len cycles once the gate opens
    always_ff @(posedge clk) begin
        chg_r <= gate_en ? chg_r + {7'h0, chg_r != 8'hff} : 8'h00;
        inrush_done <= gate_en && chg_r >= inrush_len;
    end
    // Load current only flows while the port is switched on
    assign over_overload_cut_threshold = gate_en && load_cut;
    assign over_current_limit_threshold = gate_en && load_lim;
endmodule : ppc_pd_model

// [verif/tb_ppc_port_ctrl.sv]
// Self-checking bench for the per-port class and power controller.
// Assumes ppc_pd_model answers on the cable side; short timer parameters.
`timescale 1ns/100ps
module tb_ppc_port_ctrl
    import ppc_pkg::*;
;
    localparam int FT = 100;
    localparam int ST = 50;
    localparam int LIMIT = 12000;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic auto_mode = 1'b0;
    logic detect_en = 1'b1;
    logic class_en = 1'b1;
    logic second_event_en = 1'b0;
    logic small_sense_r = 1'b0;
    logic power_on_cmd = 1'b0;
    logic power_off_cmd = 1'b0;
    logic [7:0] host_current_limit_threshold = 8'h40;
    logic [6:0] host_overload_cut_threshold = 7'h2a;
    logic [1:0] host_foldback = 2'h2;
    logic sig_good = 1'b1;
    logic [2:0] class_a = 3'h0;
    logic [2:0] class_b = 3'h0;
    logic [7:0] inrush_len = 8'h0a;
    logic load_cut = 1'b0;
    logic load_lim = 1'b0;
    logic detect_done, detect_good, inrush_done, over_overload_cut_threshold, over_current_limit_threshold;
    logic [2:0] class_meas, class_result;
    logic [1:0] drive_sel, foldback_sel;
    logic [7:0] current_limit_threshold;
    logic [6:0] overload_cut_threshold;
    logic detect_req, gate_en, limit_active, second_class_ran, type2_pd;
    logic start_fault, overload_fault, limit_fault, power_good;
    logic saw_mark = 1'b0;
    logic saw_gate = 1'b0;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    int i;

    ppc_port_ctrl #(.CLASS_CYCLES(20), .MARK_CYCLES(10), .START_CYCLES(ST), .FAULT_CYCLES(FT))
    uut (.clk, .sys_rst, .auto_mode, .detect_en, .class_en, .second_event_en, .small_sense_r,
        .power_on_cmd, .power_off_cmd, .host_current_limit_threshold, .host_overload_cut_threshold, .host_foldback, .detect_done,
        .detect_good, .class_meas, .inrush_done, .over_overload_cut_threshold, .over_current_limit_threshold, .drive_sel, .detect_req,
        .gate_en, .limit_active, .current_limit_threshold, .overload_cut_threshold,
        .foldback_sel, .class_result, .second_class_ran, .type2_pd, .start_fault,
        .overload_fault, .limit_fault, .power_good);

    ppc_pd_model pd (.clk, .drive_sel, .detect_req, .gate_en, .sig_good, .class_a, .class_b,
        .inrush_len, .load_cut, .load_lim, .detect_done, .detect_good, .class_meas,
        .inrush_done, .over_overload_cut_threshold, .over_current_limit_threshold);

    //////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Sticky monitors and the hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (drive_sel == PPC_DRV_MARK) saw_mark <= 1'b1;
        if (gate_en) saw_gate <= 1'b1;
        if (cyc == LIMIT) begin
            mismatches++;
            finish_test();
        end
    end

    //////////////////////////////////////////////////
    // Inputs change a fixed 2 ns after the edge, away from sampling
    task automatic tick();
        @(posedge clk);
        #2;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    function automatic logic pick(input int w);
        case (w)
            0: return gate_en;
            1: return power_good;
            2: return !gate_en;
            3: return drive_sel == PPC_DRV_MARK;
            4: return start_fault;
            5: return overload_fault;
            6: return limit_fault;
            default: return detect_req;
        endcase
    endfunction : pick
    // Bounded wait on one of the completion conditions above
    task automatic wait_for(input int w, input int lim);
        int n;
        n = 0;
        while (pick(w) !== 1'b1 && n < lim) begin
            tick();
            n++;
        end
        chk({7'h0, pick(w)}, 8'h01, "wait expired");
    endtask : wait_for
    // Fresh port with a new cable-side personality; 10 cycles flush the synchronisers
    task automatic start_port(input logic am, input logic se, input logic [2:0] ca,
        input logic [2:0] cb, input logic sm);
        auto_mode = am;
        second_event_en = se;
        class_a = ca;
        class_b = cb;
        small_sense_r = sm;
        sys_rst = 1'b1;
        repeat (10) tick();
        sys_rst = 1'b0;
        saw_mark = 1'b0;
        saw_gate = 1'b0;
    endtask : start_port
    // One cycle of overload followed by a quiet gap
    task automatic pulse(input int gap);
        load_cut = 1'b1;
        tick();
        load_cut = 1'b0;
        repeat (gap) tick();
    endtask : pulse
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    //////////////////////////////////////////////////
    initial begin
        // Class 2 with the option on: no second pulse; host powers up, retunes, turns off
        start_port(1'b0, 1'b1, 3'h2, 3'h2, 1'b0);
        repeat (60) tick();
        chk(8'(class_result), 8'h02, "class");
        chk(8'(second_class_ran), 8'h00, "second ran");
        chk(8'(saw_mark), 8'h00, "mark");
        chk(8'(gate_en), 8'h00, "gate before command");
        power_on_cmd = 1'b1;
        wait_for(0, 10);
        power_on_cmd = 1'b0;
        chk(current_limit_threshold, 8'h00, "inrush limit");
        wait_for(1, 30);
        tick();
        chk(current_limit_threshold, 8'h40, "programmed limit");
        chk(8'(overload_cut_threshold), 8'h2a, "cut");
        chk(8'(foldback_sel), 8'h02, "foldback");
        host_current_limit_threshold = 8'h50;
        host_overload_cut_threshold = 7'h33;
        repeat (2) tick();
        chk(current_limit_threshold, 8'h50, "limit live");
        chk(8'(overload_cut_threshold), 8'h33, "cut live");
        power_off_cmd = 1'b1;
        wait_for(2, 10);
        power_off_cmd = 1'b0;
        tick();
        chk(current_limit_threshold, 8'h00, "limit after off");
        host_current_limit_threshold = 8'hc0;
        $display("test manual_type1 done");
        // Class 4 twice in automatic mode, small sense resistor
        start_port(1'b1, 1'b1, 3'h4, 3'h4, 1'b1);
        wait_for(3, 60);
        tick();
        chk(8'(second_class_ran), 8'h01, "second ran");
        wait_for(0, 80);
        chk(8'(class_result), 8'h04, "class");
        chk(8'(type2_pd), 8'h01, "type 2");
        chk(current_limit_threshold, 8'h80, "small r inrush limit");
        $display("test auto_type2 done");
        // Class 4 then 2: no power, detection starts over
        start_port(1'b1, 1'b1, 3'h4, 3'h2, 1'b0);
        wait_for(3, 60);
        tick();
        chk(8'(second_class_ran), 8'h01, "second ran");
        wait_for(7, 60);
        chk(8'(class_result), 8'h02, "last pulse");
        chk(8'(saw_gate), 8'h00, "withheld");
        $display("test invalid_combo done");
        // Option off: class 4 runs one pulse only
        start_port(1'b0, 1'b0, 3'h4, 3'h4, 1'b0);
        repeat (60) tick();
        chk(8'(saw_mark), 8'h00, "mark");
        chk(8'(second_class_ran), 8'h00, "second ran");
        chk(8'(class_result), 8'h04, "class");
        $display("test option_off done");
        // Classification disabled: detection leads straight to power in automatic mode
        class_en = 1'b0;
        start_port(1'b1, 1'b1, 3'h4, 3'h4, 1'b0);
        wait_for(0, 30);
        chk(8'(class_result), 8'h00, "no class pulse");
        chk(8'(second_class_ran), 8'h00, "second ran");
        class_en = 1'b1;
        $display("test class_off done");
        // Inrush never ends: start window expires
        inrush_len = 8'hc8;
        start_port(1'b1, 1'b0, 3'h1, 3'h1, 1'b0);
        wait_for(0, 60);
        repeat (ST - 5) tick();
        chk(8'(gate_en), 8'h01, "still charging");
        wait_for(4, 20);
        tick();
        chk(8'(gate_en), 8'h00, "gate after start fault");
        inrush_len = 8'h0a;
        $display("test start_fault done");
        // Steady overload: no limiting, port trips after the full count
        start_port(1'b1, 1'b0, 3'h0, 3'h0, 1'b0);
        wait_for(1, 80);
        load_cut = 1'b1;
        repeat (FT - 10) tick();
        chk(8'(gate_en), 8'h01, "gate before trip");
        chk(8'(limit_active), 8'h00, "no limiting");
        wait_for(5, 30);
        tick();
        chk(8'(gate_en), 8'h00, "gate after trip");
        load_cut = 1'b0;
        $display("test overload done");
        // Current limit engaged: limit timer trips the port
        start_port(1'b1, 1'b0, 3'h0, 3'h0, 1'b0);
        wait_for(1, 80);
        load_lim = 1'b1;
        repeat (4) tick();
        chk(8'(limit_active), 8'h01, "limiting");
        wait_for(6, FT + 20);
        load_lim = 1'b0;
        $display("test limit done");
        // Low duty overload decays; higher duty accumulates and trips
        start_port(1'b1, 1'b0, 3'h0, 3'h0, 1'b0);
        wait_for(1, 80);
        repeat (100) pulse(20);
        chk(8'(overload_fault), 8'h00, "low duty");
        for (i = 0; i < 300 && overload_fault !== 1'b1; i++) pulse(8);
        chk(8'(overload_fault), 8'h01, "high duty");
        $display("test duty done");
        finish_test();
    end
endmodule : tb_ppc_port_ctrl
